// ==== hw/current_key_if.sv ====
`timescale 1ns/1ps
// Motor current update request and result
interface current_key_if;
  logic        key_req;
  logic [15:0] req_value;
  logic [15:0] cfg_value;
  logic [15:0] applied_value;

  modport decoder (output key_req, output req_value, output cfg_value, input applied_value);
  modport unit    (input key_req, input req_value, input cfg_value, output applied_value);
endinterface

// ==== hw/current_key_unit.sv ====
`timescale 1ns/1ps
`include "motion_cmd_regs.svh"
module current_key_unit #(
  parameter logic [15:0] CUR_MAX = `CUR_MAX_DEFAULT
) (
  // Clock and reset
  input  wire logic  sys_clk_in,
  input  wire logic  rst_in,
  // Request from decoder
  current_key_if.unit cur
);

  logic        valid;
  logic        ovr_q;
  logic        ovr_d;
  logic [15:0] val_q;
  logic [15:0] val_d;
  logic [15:0] app_q;
  logic [15:0] app_d;

  always_comb begin
    valid = ~cur.req_value[0] && (cur.req_value >= `CUR_MIN) && (cur.req_value <= CUR_MAX);
    ovr_d = ovr_q;
    val_d = val_q;
    if (cur.key_req) begin
      ovr_d = valid;
      val_d = valid ? cur.req_value : val_q;
    end
    app_d = ovr_d ? val_d : cur.cfg_value;
  end

  // Current registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ovr_q <= 1'b0;
      val_q <= `WORD_RST;
      app_q <= `WORD_RST;
    end else begin
      ovr_q <= ovr_d;
      val_q <= val_d;
      app_q <= app_d;
    end
  end

  assign cur.applied_value = app_q;

  AST_CUR_INVALID: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cur.key_req && cur.req_value[0] |=> app_q == $past(cur.cfg_value))
    else $error("odd current was applied");

  AST_CUR_VALID: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cur.key_req && valid |=> app_q == $past(cur.req_value) ##1 app_q == $past(cur.req_value, 2)
      || $past(cur.key_req))
    else $error("valid current not applied");

endmodule

// ==== hw/motion_cmd_pkg.sv ====
package motion_cmd_pkg;

  // Kind of move handed to the profile generator
  typedef enum logic [2:0] {
    MOVE_NONE,
    MOVE_ABS,
    MOVE_REL,
    MOVE_JOG,
    MOVE_HOME,
    MOVE_BLEND,
    MOVE_DWELL
  } move_kind_t;

endpackage

// ==== hw/motion_cmd_regs.svh ====
// Operation
// - Rising clockwise jog bit starts a clockwise jog move.
// - Rising counter-clockwise home bit searches home switch moving counter-clockwise.
// - Rising clockwise home bit searches home switch moving clockwise.
// - Rising immediate stop bit halts all motion with no deceleration.
// - Stop during a move invalidates position; stop while idle keeps it.
// - Rising hold bit ramps to starting speed, stops, keeps move held.
// - Rising resume completes a held move; any new move discards it.
// - Rising relative or absolute bit runs that move with parameter words.
// - Drive enable bit gates motor current; never enabled without valid configuration.
// - General purpose output conducts while output state bit is one.
// - With proximity qualification, home input counts only while proximity bit set.
// - Reset errors with clear-fault bit clears driver faults; enable held low.
// - Assembled move runs blend when type bit zero, dwell when one.
// - Indexed bit defers a move until the start input goes active.
// - Jog runs standard when registration bit zero, registration when one.
// - Gearing bit selects gearing; encoder followed only while a jog bit set.
// - Save bit stores assembled move when programming bit falls one to zero.
// - Blend direction bit zero gives clockwise, one counter-clockwise.
// - Encoder registration bit with relative/absolute move stops on encoder target.
// - Current keys 1,0,1 apply new current at any time except during a registration jog, and echo it.
// - Odd or out-of-range current silently ignored; configured current kept.
// - Commands accepted only on zero-to-one transitions, one bit at a time.
// - Reset errors clears all errors and the move-complete flag.
`ifndef MOTION_CMD_REGS_SVH
`define MOTION_CMD_REGS_SVH

// Command word zero bit positions
`define W0_ABS_MOVE      0
`define W0_REL_MOVE      1
`define W0_HOLD          2
`define W0_RESUME        3
`define W0_ESTOP         4
`define W0_HOME_CW       5
`define W0_HOME_CCW      6
`define W0_JOG_CLOCKWISE        7
`define W0_JOG_COUNTERCLOCKWISE 8
`define W0_RESET_ERR     10
`define W0_PROG_ASM      11
`define W0_RUN_ASM       13

// Command word one bit positions
`define W1_DRIVE_EN      15
`define W1_AUX_LEVEL     13
`define W1_PROX          11
`define W1_CLR_FAULT     10
`define W1_ASM_DWELL     9
`define W1_INDEXED       8
`define W1_REGISTRATION  7
`define W1_GEARING       6
`define W1_STORE_NV      5
`define W1_UNLOCK_2      5
`define W1_BLEND_CCW     4
`define W1_ENC_REG       2
`define W1_UNLOCK_1      1
`define W1_UNLOCK_0      0

// Current key code (bits 2,1,0) and limits in 0.1 A
`define CUR_KEY_CODE     3'h5
`define CUR_MIN          16'h000a
`define CUR_MAX_DEFAULT  16'h003c

// Reset values
`define WORD_RST         16'h0000

`endif

// ==== hw/motion_command_word_decoder.sv ====
`timescale 1ns/1ps
`include "motion_cmd_regs.svh"
module motion_command_word_decoder #(
  parameter logic [15:0] CUR_MAX = `CUR_MAX_DEFAULT
) (
  // Clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  // Command data from the network master
  input  wire logic [15:0]               motion_command_word_zero_in,
  input  wire logic [15:0]               motion_command_word_one_in,
  input  wire logic [15:0]               motor_current_in,
  input  wire logic [15:0]               dwell_time_in,
  // Configuration and device state
  input  wire logic                      config_valid_in,
  input  wire logic                      aux_is_gp_in,
  input  wire logic                      prox_qualify_in,
  input  wire logic                      fault_level_in,
  input  wire logic [15:0]               cfg_current_in,
  input  wire logic                      home_switch_in,
  input  wire logic                      index_start_in,
  input  wire logic                      move_busy_in,
  input  wire logic                      position_restore_in,
  // Move launch to the profile generator
  output logic                           move_start_out,
  output motion_cmd_pkg::move_kind_t     move_kind_out,
  output logic                           move_ccw_out,
  output logic                           registration_out,
  output logic                           encoder_reg_out,
  output logic [15:0]                    dwell_time_out,
  output logic                           index_wait_out,
  // Move control
  output logic                           immediate_stop_out,
  output logic                           hold_out,
  output logic                           resume_out,
  output logic                           held_out,
  output logic                           position_valid_out,
  // Errors and storage
  output logic                           clear_errors_out,
  output logic                           clear_fault_out,
  output logic                           store_nv_out,
  // Static controls
  output logic                           drive_enable_out,
  output logic                           aux_output_out,
  output logic                           home_qualified_out,
  output logic                           gearing_out,
  output logic                           gear_follow_out,
  output logic [15:0]                    motor_current_out
);

  logic [15:0] rise;
  logic [15:0] fall;
  logic        start_rise;
  logic        jog_level;
  logic        new_cmd;
  logic        new_ccw;
  motion_cmd_pkg::move_kind_t new_kind;

  logic        start_q,  start_d;
  motion_cmd_pkg::move_kind_t kind_q, kind_d;
  logic        ccw_q,    ccw_d;
  logic        reg_q,    reg_d;
  logic        enc_q,    enc_d;
  logic [15:0] dwell_q,  dwell_d;
  logic        pend_q,   pend_d;
  logic        estop_q,  estop_d;
  logic        hold_q,   hold_d;
  logic        resume_q, resume_d;
  logic        held_q,   held_d;
  logic        posv_q,   posv_d;
  logic        clre_q,   clre_d;
  logic        clrf_q,   clrf_d;
  logic        store_q,  store_d;
  logic        drv_q,    drv_d;
  logic        aux_q,    aux_d;
  logic        homeq_q,  homeq_d;
  logic        gear_q,   gear_d;
  logic        follow_q, follow_d;

  current_key_if cur ();

  // Zero-to-one transitions of command word zero
  rise_detect #(.W(16)) u_word0_edges (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (motion_command_word_zero_in),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // Indexer start input edge
  rise_detect #(.W(1)) u_start_edge (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   (index_start_in),
    .rise_out   (start_rise),
    .fall_out   ()
  );

  // On-the-fly motor current
  current_key_unit #(.CUR_MAX(CUR_MAX)) u_current (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .cur        (cur)
  );

  assign jog_level = motion_command_word_zero_in[`W0_JOG_CLOCKWISE] | motion_command_word_zero_in[`W0_JOG_COUNTERCLOCKWISE];

  assign cur.key_req   = ({motion_command_word_one_in[`W1_UNLOCK_2], motion_command_word_one_in[`W1_UNLOCK_1],
                           motion_command_word_one_in[`W1_UNLOCK_0]} == `CUR_KEY_CODE)
                         && !(motion_command_word_one_in[`W1_REGISTRATION] && jog_level);
  assign cur.req_value = motor_current_in;
  assign cur.cfg_value = cfg_current_in;

  // Move command decode; a simultaneous second rise is resolved by fixed order
  always_comb begin
    new_cmd  = 1'b1;
    new_ccw  = 1'b0;
    new_kind = motion_cmd_pkg::MOVE_NONE;
    if (rise[`W0_ABS_MOVE]) begin
      new_kind = motion_cmd_pkg::MOVE_ABS;
    end else if (rise[`W0_REL_MOVE]) begin
      new_kind = motion_cmd_pkg::MOVE_REL;
    end else if (rise[`W0_JOG_CLOCKWISE] && !motion_command_word_one_in[`W1_GEARING]) begin
      new_kind = motion_cmd_pkg::MOVE_JOG;
    end else if (rise[`W0_JOG_COUNTERCLOCKWISE] && !motion_command_word_one_in[`W1_GEARING]) begin
      new_kind = motion_cmd_pkg::MOVE_JOG;
      new_ccw  = 1'b1;
    end else if (rise[`W0_HOME_CW]) begin
      new_kind = motion_cmd_pkg::MOVE_HOME;
    end else if (rise[`W0_HOME_CCW]) begin
      new_kind = motion_cmd_pkg::MOVE_HOME;
      new_ccw  = 1'b1;
    end else if (rise[`W0_RUN_ASM]) begin
      new_kind = motion_command_word_one_in[`W1_ASM_DWELL] ? motion_cmd_pkg::MOVE_DWELL
                                              : motion_cmd_pkg::MOVE_BLEND;
      new_ccw  = !motion_command_word_one_in[`W1_ASM_DWELL] && motion_command_word_one_in[`W1_BLEND_CCW];
    end else begin
      new_cmd  = 1'b0;
    end
  end

  // Motion sequencing next state
  always_comb begin
    start_d  = 1'b0;
    estop_d  = 1'b0;
    hold_d   = 1'b0;
    resume_d = 1'b0;
    kind_d   = kind_q;
    ccw_d    = ccw_q;
    reg_d    = reg_q;
    enc_d    = enc_q;
    dwell_d  = dwell_q;
    pend_d   = pend_q;
    held_d   = held_q;
    posv_d   = posv_q | position_restore_in;
    if (rise[`W0_ESTOP]) begin
      estop_d = 1'b1;
      pend_d  = 1'b0;
      held_d  = 1'b0;
      if (move_busy_in) begin
        posv_d = 1'b0;
      end
    end else if (rise[`W0_HOLD]) begin
      if (move_busy_in) begin
        hold_d = 1'b1;
        held_d = 1'b1;
      end
    end else if (rise[`W0_RESUME]) begin
      if (held_q) begin
        resume_d = 1'b1;
        held_d   = 1'b0;
      end
    end else if (new_cmd) begin
      kind_d  = new_kind;
      ccw_d   = new_ccw;
      reg_d   = (new_kind == motion_cmd_pkg::MOVE_JOG) && motion_command_word_one_in[`W1_REGISTRATION];
      enc_d   = ((new_kind == motion_cmd_pkg::MOVE_ABS) || (new_kind == motion_cmd_pkg::MOVE_REL))
                && motion_command_word_one_in[`W1_ENC_REG];
      dwell_d = dwell_time_in;
      held_d  = 1'b0;
      if (motion_command_word_one_in[`W1_INDEXED]) begin
        pend_d = 1'b1;
      end else begin
        pend_d  = 1'b0;
        start_d = 1'b1;
      end
    end else if (pend_q && start_rise) begin
      pend_d  = 1'b0;
      start_d = 1'b1;
    end
  end

  // Error, storage and static control next values
  always_comb begin
    clre_d   = rise[`W0_RESET_ERR];
    clrf_d   = rise[`W0_RESET_ERR] && motion_command_word_one_in[`W1_CLR_FAULT] && !motion_command_word_one_in[`W1_DRIVE_EN];
    store_d  = fall[`W0_PROG_ASM] && motion_command_word_one_in[`W1_STORE_NV];
    drv_d    = motion_command_word_one_in[`W1_DRIVE_EN] && config_valid_in;
    aux_d    = aux_is_gp_in ? motion_command_word_one_in[`W1_AUX_LEVEL] : fault_level_in;
    homeq_d  = prox_qualify_in ? (home_switch_in && motion_command_word_one_in[`W1_PROX]) : home_switch_in;
    gear_d   = motion_command_word_one_in[`W1_GEARING];
    follow_d = motion_command_word_one_in[`W1_GEARING] && jog_level;
  end

  // State registers; position starts invalid until restored
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_q  <= 1'b0;
      kind_q   <= motion_cmd_pkg::MOVE_NONE;
      ccw_q    <= 1'b0;
      reg_q    <= 1'b0;
      enc_q    <= 1'b0;
      dwell_q  <= `WORD_RST;
      pend_q   <= 1'b0;
      estop_q  <= 1'b0;
      hold_q   <= 1'b0;
      resume_q <= 1'b0;
      held_q   <= 1'b0;
      posv_q   <= 1'b0;
      clre_q   <= 1'b0;
      clrf_q   <= 1'b0;
      store_q  <= 1'b0;
      drv_q    <= 1'b0;
      aux_q    <= 1'b0;
      homeq_q  <= 1'b0;
      gear_q   <= 1'b0;
      follow_q <= 1'b0;
    end else begin
      start_q  <= start_d;
      kind_q   <= kind_d;
      ccw_q    <= ccw_d;
      reg_q    <= reg_d;
      enc_q    <= enc_d;
      dwell_q  <= dwell_d;
      pend_q   <= pend_d;
      estop_q  <= estop_d;
      hold_q   <= hold_d;
      resume_q <= resume_d;
      held_q   <= held_d;
      posv_q   <= posv_d;
      clre_q   <= clre_d;
      clrf_q   <= clrf_d;
      store_q  <= store_d;
      drv_q    <= drv_d;
      aux_q    <= aux_d;
      homeq_q  <= homeq_d;
      gear_q   <= gear_d;
      follow_q <= follow_d;
    end
  end

  // Output drive
  assign move_start_out     = start_q;
  assign move_kind_out      = kind_q;
  assign move_ccw_out       = ccw_q;
  assign registration_out   = reg_q;
  assign encoder_reg_out    = enc_q;
  assign dwell_time_out     = dwell_q;
  assign index_wait_out     = pend_q;
  assign immediate_stop_out = estop_q;
  assign hold_out           = hold_q;
  assign resume_out         = resume_q;
  assign held_out           = held_q;
  assign position_valid_out = posv_q;
  assign clear_errors_out   = clre_q;
  assign clear_fault_out    = clrf_q;
  assign store_nv_out       = store_q;
  assign drive_enable_out   = drv_q;
  assign aux_output_out     = aux_q;
  assign home_qualified_out = homeq_q;
  assign gearing_out        = gear_q;
  assign gear_follow_out    = follow_q;
  assign motor_current_out  = cur.applied_value;

  AST_ESTOP_PULSE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rise[`W0_ESTOP] |=> immediate_stop_out && !move_start_out && !index_wait_out)
    else $error("stop not issued");

  AST_POS_INVALID: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rise[`W0_ESTOP] && move_busy_in |=> !position_valid_out)
    else $error("position kept valid after stop in move");

  AST_POS_KEEP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rise[`W0_ESTOP] && !move_busy_in && position_valid_out |=> position_valid_out)
    else $error("idle stop invalidated position");

  AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !rise[`W0_ESTOP] && rise[`W0_HOLD] && move_busy_in |=> hold_out && held_out)
    else $error("hold not taken");

  AST_RESUME: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    resume_out |-> $past(held_out) && !held_out)
    else $error("resume without held move");

  AST_DISCARD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    move_start_out && !$past(index_wait_out) |-> !held_out)
    else $error("held move survived new move");

  AST_INDEX_FIRE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    index_wait_out && start_rise && !rise[`W0_ESTOP] && !new_cmd |=> move_start_out ##1 !move_start_out)
    else $error("indexed move not released");

  AST_JOG_CLOCKWISE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rise == 16'h0080 && !motion_command_word_one_in[`W1_GEARING] && !motion_command_word_one_in[`W1_INDEXED]
    |=> move_start_out && move_kind_out == motion_cmd_pkg::MOVE_JOG && !move_ccw_out)
    else $error("clockwise jog not launched");

  AST_DRIVE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    drive_enable_out |-> $past(config_valid_in) && $past(motion_command_word_one_in[`W1_DRIVE_EN]))
    else $error("driver enabled without configuration");

  AST_STORE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    store_nv_out |-> $past(motion_command_word_zero_in[`W0_PROG_ASM], 2) && !$past(motion_command_word_zero_in[`W0_PROG_ASM]))
    else $error("store without programming fall");

endmodule

// ==== hw/rise_detect.sv ====
`timescale 1ns/1ps
module rise_detect #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  // Level in, edges out
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out,
  output logic      [W-1:0] fall_out
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;
  logic         arm_q;
  logic         arm_d;

  // Edges only after one sample, so levels held through reset never fire
  always_comb begin
    prev_d   = level_in;
    arm_d    = 1'b1;
    rise_out = arm_q ? (level_in & ~prev_q) : '0;
    fall_out = arm_q ? (~level_in & prev_q) : '0;
  end

  // Sample register
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= '0;
      arm_q  <= 1'b0;
    end else begin
      prev_q <= prev_d;
      arm_q  <= arm_d;
    end
  end

endmodule

// ==== verif/motion_command_word_decoder_tb_top.sv ====
`timescale 1ns/1ps
module motion_command_word_decoder_tb_top;
  logic                       sys_clk_in;
  logic                       rst_in;
  logic [15:0]                w0, w1, cur_req, dwell, cfg_cur, dwell_o, cur_o;
  logic                       cfg_ok, aux_gp, prox_cfg, fault_lvl, home_sw, idx_start;
  logic                       busy, restore, m_start, m_ccw, m_reg, m_enc, idx_wait;
  logic                       stop_p, hold_p, resume_p, held, pos_ok, clr_err, clr_flt;
  logic                       store, drv_en, aux_o, home_q, gear, gear_f;
  logic [6:0]                 pulses;
  logic [6:0]                 s;
  motion_cmd_pkg::move_kind_t kind;
  int                         fail_count;
  int                         num_checks;

  // One bit per pulse output, indexed by the waits below
  assign pulses = {store, clr_flt, clr_err, resume_p, hold_p, stop_p, m_start};

  network_master_model network_master_model_i (
    .sys_clk_in(sys_clk_in), .motion_command_word_zero_out(w0), .motion_command_word_one_out(w1),
    .motor_current_out(cur_req), .dwell_time_out(dwell));

  motion_command_word_decoder motion_command_word_decoder_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .motion_command_word_zero_in(w0), .motion_command_word_one_in(w1),
    .motor_current_in(cur_req), .dwell_time_in(dwell), .config_valid_in(cfg_ok),
    .aux_is_gp_in(aux_gp), .prox_qualify_in(prox_cfg), .fault_level_in(fault_lvl),
    .cfg_current_in(cfg_cur), .home_switch_in(home_sw), .index_start_in(idx_start),
    .move_busy_in(busy), .position_restore_in(restore), .move_start_out(m_start),
    .move_kind_out(kind), .move_ccw_out(m_ccw), .registration_out(m_reg),
    .encoder_reg_out(m_enc), .dwell_time_out(dwell_o), .index_wait_out(idx_wait),
    .immediate_stop_out(stop_p), .hold_out(hold_p), .resume_out(resume_p),
    .held_out(held), .position_valid_out(pos_ok), .clear_errors_out(clr_err),
    .clear_fault_out(clr_flt), .store_nv_out(store), .drive_enable_out(drv_en),
    .aux_output_out(aux_o), .home_qualified_out(home_q), .gearing_out(gear),
    .gear_follow_out(gear_f), .motor_current_out(cur_o));

  // Free-running clock, 4 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Bounded wait for one pulse, then it must be gone a cycle later
  task automatic wait_pulse(input int idx, output logic [6:0] seen);
    int k;
    k = 0;
    while (pulses[idx] !== 1'b1 && k < 6) begin
      tick(1);
      k++;
    end
    seen = pulses;
    check(16'(pulses[idx]), 16'h0001);
    tick(1);
    check(16'(pulses[idx]), 16'h0000);
  endtask

  // Every move kind with its qualifier bits in word one
  // move launch table
  task automatic t_moves();
    int bits[8] = '{0, 1, 7, 8, 5, 6, 13, 13};
    logic [15:0] q[8] = '{16'h0004, 16'h0, 16'h0080, 16'h0, 16'h0, 16'h0, 16'h0010, 16'h0200};
    logic ccw[8] = '{0, 0, 0, 1, 0, 1, 1, 0};
    motion_cmd_pkg::move_kind_t k[8] = '{motion_cmd_pkg::MOVE_ABS, motion_cmd_pkg::MOVE_REL,
      motion_cmd_pkg::MOVE_JOG, motion_cmd_pkg::MOVE_JOG, motion_cmd_pkg::MOVE_HOME,
      motion_cmd_pkg::MOVE_HOME, motion_cmd_pkg::MOVE_BLEND, motion_cmd_pkg::MOVE_DWELL};
    network_master_model_i.load(16'h0000, 16'h01f4);
    for (int i = 0; i < 8; i++) begin
      network_master_model_i.issue(bits[i], q[i]);
      wait_pulse(0, s);
      check(16'(kind), 16'(k[i]));
      check(16'(m_ccw), 16'(ccw[i]));
      check(16'(m_reg), 16'(q[i][7]));
      check(16'(m_enc), 16'(q[i][2]));
    end
    check(dwell_o, 16'h01f4);
  endtask

  // Stop while idle keeps position, stop while busy loses it
  task automatic t_stop();
    restore = 1'b1;
    tick(1);
    restore = 1'b0;
    tick(2);
    network_master_model_i.issue(4, 16'h0);
    wait_pulse(1, s);
    check(16'(pos_ok), 16'h0001);
    busy = 1'b1;
    network_master_model_i.issue(4, 16'h0);
    wait_pulse(1, s);
    check(16'(pos_ok), 16'h0000);
  endtask

  // Hold, resume, then a hold dropped by a new move
  task automatic t_hold();
    network_master_model_i.issue(2, 16'h0);
    wait_pulse(2, s);
    check(16'(held), 16'h0001);
    network_master_model_i.issue(3, 16'h0);
    wait_pulse(3, s);
    check(16'(held), 16'h0000);
    network_master_model_i.issue(2, 16'h0);
    wait_pulse(2, s);
    network_master_model_i.issue(0, 16'h0);
    wait_pulse(0, s);
    check(16'(held), 16'h0000);
    busy = 1'b0;
  endtask

  // Indexed move waits for the start input
  task automatic t_index();
    network_master_model_i.issue(1, 16'h0100);
    tick(4);
    check(16'(idx_wait), 16'h0001);
    check(16'(m_start), 16'h0000);
    idx_start = 1'b1;
    wait_pulse(0, s);
    check(16'(idx_wait), 16'h0000);
    idx_start = 1'b0;
  endtask

  // Level controls of word one; the drive enable bit is set before configuration is made valid
  task automatic t_levels();
    network_master_model_i.put(16'h0, 16'h8000);
    tick(2);
    check(16'(drv_en), 16'h0000);
    cfg_ok = 1'b1;
    tick(2);
    check(16'(drv_en), 16'h0001);
    network_master_model_i.put(16'h0, 16'h2000);
    tick(2);
    check(16'(aux_o), 16'h0001);
    // Fault output role ignores the state bit
    aux_gp = 1'b0;
    tick(2);
    check(16'(aux_o), 16'h0000);
    aux_gp = 1'b1;
    prox_cfg = 1'b1;
    home_sw = 1'b1;
    network_master_model_i.put(16'h0, 16'h0040);
    tick(2);
    check(16'(home_q), 16'h0000);
    check(16'(gear), 16'h0001);
    check(16'(gear_f), 16'h0000);
    network_master_model_i.put(16'h0080, 16'h0840);
    tick(2);
    check(16'(home_q), 16'h0001);
    check(16'(gear_f), 16'h0001);
  endtask

  // Error reset with the fault clear bit, drive enable low then high, then the save on fall
  task automatic t_errors();
    network_master_model_i.issue(10, 16'h0400);
    wait_pulse(4, s);
    check(16'(s[5]), 16'h0001);
    network_master_model_i.issue(10, 16'h8400);
    wait_pulse(4, s);
    check(16'(s[5]), 16'h0000);
    network_master_model_i.put(16'h0800, 16'h0020);
    network_master_model_i.put(16'h0000, 16'h0020);
    wait_pulse(6, s);
  endtask

  // Current keys: even values in range applied, others fall back
  task automatic t_current();
    logic [15:0] req[6] = '{16'h0014, 16'h0015, 16'h003c, 16'h003e, 16'h0008, 16'h000a};
    logic [15:0] exp[6] = '{16'h0014, 16'h001e, 16'h003c, 16'h001e, 16'h001e, 16'h000a};
    for (int i = 0; i < 6; i++) begin
      network_master_model_i.load(req[i], 16'h0);
      network_master_model_i.put(16'h0, 16'h0021);
      tick(2);
      check(cur_o, exp[i]);
    end
    // Registration jog first, so the keys never see the new value unblocked
    network_master_model_i.put(16'h0080, 16'h00a1);
    network_master_model_i.load(16'h0010, 16'h0);
    tick(3);
    check(cur_o, 16'h000a);
    network_master_model_i.put(16'h0, 16'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard at 5000 cycles, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #(4 * 5000);
    fail_count++;
    end_of_test();
  end

  initial begin
    {cfg_ok, aux_gp, prox_cfg, fault_lvl, home_sw, idx_start, busy, restore} = 8'h00;
    cfg_cur = 16'h001e;
    fail_count = 0;
    num_checks = 0;
    rst_in = 1'b1;
    tick(20);
    rst_in = 1'b0;
    tick(2);
    check(16'(pos_ok), 16'h0000);
    aux_gp = 1'b1;
    t_moves();
    t_stop();
    t_hold();
    t_index();
    t_levels();
    t_errors();
    t_current();
    end_of_test();
  end
endmodule

// ==== verif/network_master_model.sv ====
`timescale 1ns/1ps
module network_master_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Cyclic output data
  output logic      [15:0] motion_command_word_zero_out,
  output logic      [15:0] motion_command_word_one_out,
  output logic      [15:0] motor_current_out,
  output logic      [15:0] dwell_time_out
);
  // Quiet bus before the first cycle
  initial begin
    motion_command_word_zero_out = 16'h0000;
    motion_command_word_one_out = 16'h0000;
    motor_current_out = 16'h0000;
    dwell_time_out = 16'h0000;
  end

  // Writes one cycle of output data; the words change only at the falling edge
  // mode bit and reserved bits zero
  task automatic put(input logic [15:0] w0, input logic [15:0] w1);
    @(negedge sys_clk_in);
    motion_command_word_zero_out <= w0 & 16'h7fff;
    motion_command_word_one_out <= w1 & 16'haff7;
  endtask

  // Parameter words ride along with the next command
  task automatic load(input logic [15:0] cur, input logic [15:0] dwell);
    @(negedge sys_clk_in);
    motor_current_out <= cur;
    dwell_time_out <= dwell;
  endtask

  // Word zero goes through zero first so exactly one bit rises
  // single rising bit
  task automatic issue(input int b, input logic [15:0] w1);
    put(16'h0000, w1);
    put(16'h0001 << b, w1);
  endtask
endmodule
